// ==== pmt_pkg.sv ====
package pmt_pkg;

  // ********************************************
  // Program store geometry
  // ********************************************
  localparam int PROG_WORDS = 4096;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 12;
  localparam int BYTE_W = 8;
  localparam int PAGE_W = ADDR_W - BYTE_W;

  // ********************************************
  // Reset values and fixed addresses
  // ********************************************
  localparam logic [ADDR_W-1:0] PC_RESET = 12'h000;
  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hF;
  localparam logic [BYTE_W-1:0] PTR_RESET = 8'h00;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // ********************************************
  // Serial programming frame: address then data, MSB first
  // ********************************************
  localparam int FRAME_BITS = ADDR_W + WORD_W;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] FRAME_LAST = 5'h1B;

  // ********************************************
  // Clock
  // ********************************************
  localparam int MCLK_PERIOD_NS = 100;

  // ********************************************
  // Table read sequencer states
  // ********************************************
  typedef enum logic [1:0] {
    PMT_ST_IDLE = 2'b01,
    PMT_ST_TABLE = 2'b10
  } pmt_state_e;

endpackage

// ==== pmt_flash_array.sv ====
`timescale 1ns/1ps
`default_nettype none

module pmt_flash_array #(
  parameter int WORDS = pmt_pkg::PROG_WORDS,
  parameter int AW = pmt_pkg::ADDR_W,
  parameter int DW = pmt_pkg::WORD_W
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);

  // ********************************************
  // Storage
  // ********************************************
  logic [DW-1:0] mem_reg [WORDS];

  // Words only change through the programming port, never from code
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  // Read is combinational; the caller registers the result
  assign rd_data = mem_reg[rd_addr];

endmodule

`default_nettype wire

// ==== pmt_prog_port.sv ====
`timescale 1ns/1ps
`default_nettype none

module pmt_prog_port (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic prog_mode,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out_reg,
  output logic prog_serial_data_oe_n_reg,
  output logic wr_en_reg,
  output logic [pmt_pkg::ADDR_W-1:0] wr_addr_reg,
  output logic [pmt_pkg::WORD_W-1:0] wr_data_reg
);

  // ********************************************
  // Clock edge detection
  // ********************************************
  logic clk_prev_reg;
  logic clk_rise;
  logic [pmt_pkg::FRAME_BITS-1:0] shift_reg;
  logic [pmt_pkg::CNT_W-1:0] count_reg;

  // Pin inputs are synchronous, so one stage is enough for the edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= prog_serial_clock;
    end
  end

  assign clk_rise = prog_serial_clock & ~clk_prev_reg;

  // ********************************************
  // Frame shifter
  // ********************************************
  // Bits enter on the programmer's clock rising edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      count_reg <= '0;
    end else if (!prog_mode) begin
      count_reg <= '0;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[pmt_pkg::FRAME_BITS-2:0], prog_serial_data_in};
      count_reg <= (count_reg == pmt_pkg::FRAME_LAST) ? '0 : count_reg + 5'h01;
    end
  end

  // Write strobe rises on the same edge that takes in the last bit of a frame
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      wr_en_reg <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
    end else begin
      wr_en_reg <= prog_mode & clk_rise & (count_reg == pmt_pkg::FRAME_LAST);
      if (prog_mode & clk_rise & (count_reg == pmt_pkg::FRAME_LAST)) begin
        wr_addr_reg <= shift_reg[pmt_pkg::FRAME_BITS-2:pmt_pkg::WORD_W-1];
        wr_data_reg <= {shift_reg[pmt_pkg::WORD_W-2:0], prog_serial_data_in};
      end
    end
  end

  // ********************************************
  // Acknowledge drive on the shared data line
  // ********************************************
  // Device pulls the line low as an ack until the next programmer clock rising edge or until programming mode ends;
  // the same pin pair serves debug on the emulation part
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prog_serial_data_oe_n_reg <= 1'b1;
      prog_serial_data_out_reg <= 1'b0;
    end else if (!prog_mode) begin
      prog_serial_data_oe_n_reg <= 1'b1;
    end else if (clk_rise) begin
      prog_serial_data_oe_n_reg <= (count_reg != pmt_pkg::FRAME_LAST);
      prog_serial_data_out_reg <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ==== pmt_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Program store holds 4K words of 16 bits, addressed by the PC.
// - After reset the PC is zero and fetching starts there.
// - Table data may sit at any word, located by a separate pointer.
// - Table address is the low four bits of the high pointer joined with the low pointer.
// - Table read writes the low byte to the named data register.
// - Every table read loads the high byte into the table-high latch.
// - The table-high latch is read-only; only table reads change it.
// - Page form uses the low pointer as offset in the last page.
// - Each table read takes two instruction cycles.
// - Programming uses one two-way serial data line and a programmer clock.
// - On the emulation part the same two pins serve debug and programming.
module pmt_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cpu_step,
  input wire logic pc_load,
  input wire logic [pmt_pkg::ADDR_W-1:0] pc_load_value,
  input wire logic ptr_low_wr,
  input wire logic ptr_high_wr,
  input wire logic [pmt_pkg::BYTE_W-1:0] ptr_wdata,
  input wire logic tab_rd_req,
  input wire logic tab_rd_lastpage,
  input wire logic [pmt_pkg::BYTE_W-1:0] tab_rd_dest,
  input wire logic prog_mode,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_n,
  output logic [pmt_pkg::ADDR_W-1:0] pc_reg,
  output logic [pmt_pkg::BYTE_W-1:0] pc_low_byte,
  output logic [pmt_pkg::WORD_W-1:0] instr_word_reg,
  output logic [pmt_pkg::ADDR_W-1:0] instr_addr_reg,
  output logic instr_valid_reg,
  output logic busy_reg,
  output logic [pmt_pkg::BYTE_W-1:0] tbl_ptr_low_reg,
  output logic [pmt_pkg::BYTE_W-1:0] tbl_ptr_high_reg,
  output logic [pmt_pkg::ADDR_W-1:0] tab_addr_reg,
  output logic tab_wr_en_reg,
  output logic [pmt_pkg::BYTE_W-1:0] tab_dest_reg,
  output logic [pmt_pkg::BYTE_W-1:0] tab_low_data_reg,
  output logic [pmt_pkg::BYTE_W-1:0] table_high_latch
);

  // ********************************************
  // Declarations
  // ********************************************
  pmt_pkg::pmt_state_e state_reg;
  pmt_pkg::pmt_state_e state_next;
  logic [pmt_pkg::WORD_W-1:0] rd_word;
  logic [pmt_pkg::ADDR_W-1:0] rd_addr;
  logic [pmt_pkg::BYTE_W-1:0] dest_hold_reg;
  logic [pmt_pkg::BYTE_W-1:0] table_high_latch_reg;
  logic fetch;
  logic tab_accept;
  logic prog_wr_en;
  logic [pmt_pkg::ADDR_W-1:0] prog_wr_addr;
  logic [pmt_pkg::WORD_W-1:0] prog_wr_data;

  // Joins a page select and an in-page offset into one word address
  function automatic logic [pmt_pkg::ADDR_W-1:0] table_address(
    input logic lastpage,
    input logic [pmt_pkg::BYTE_W-1:0] high_ptr,
    input logic [pmt_pkg::BYTE_W-1:0] low_ptr
  );
    logic [pmt_pkg::PAGE_W-1:0] page;
    page = lastpage ? pmt_pkg::LAST_PAGE : high_ptr[pmt_pkg::PAGE_W-1:0];
    return {page, low_ptr};
  endfunction

  // ********************************************
  // Submodules
  // ********************************************
  // Flop storage of the whole program space
  pmt_flash_array #(
    .WORDS(pmt_pkg::PROG_WORDS),
    .AW(pmt_pkg::ADDR_W),
    .DW(pmt_pkg::WORD_W)
  ) u_array (
    .mclk(mclk),
    .wr_en(prog_wr_en),
    .wr_addr(prog_wr_addr),
    .wr_data(prog_wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_word)
  );

  pmt_prog_port u_prog (
    .mclk(mclk),
    .rst_n(rst_n),
    .prog_mode(prog_mode),
    .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_in(prog_serial_data_in),
    .prog_serial_data_out_reg(prog_serial_data_out),
    .prog_serial_data_oe_n_reg(prog_serial_data_oe_n),
    .wr_en_reg(prog_wr_en),
    .wr_addr_reg(prog_wr_addr),
    .wr_data_reg(prog_wr_data)
  );

  // ********************************************
  // Sequencing
  // ********************************************
  // Core is frozen while programming so a half-written word is never run
  assign fetch = cpu_step & ~prog_mode & (state_reg == pmt_pkg::PMT_ST_IDLE) & ~tab_rd_req;
  assign tab_accept = tab_rd_req & ~prog_mode & (state_reg == pmt_pkg::PMT_ST_IDLE);

  // The single read port is shared; the table cycle takes it from fetch
  assign rd_addr = (state_reg == pmt_pkg::PMT_ST_TABLE) ? tab_addr_reg : pc_reg;

  // Table read: accept cycle plus one access cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      pmt_pkg::PMT_ST_IDLE: begin
        if (tab_accept) begin
          state_next = pmt_pkg::PMT_ST_TABLE;
        end
      end
      pmt_pkg::PMT_ST_TABLE: begin
        state_next = pmt_pkg::PMT_ST_IDLE;
      end
      default: begin
        state_next = pmt_pkg::PMT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= pmt_pkg::PMT_ST_IDLE;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_reg <= tab_accept;
    end
  end

  // ********************************************
  // Program counter and fetch
  // ********************************************
  // Reset vector is word zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= pmt_pkg::PC_RESET;
    end else if (fetch) begin
      pc_reg <= pc_load ? pc_load_value : pc_reg + 12'h001;
    end
  end

  // Low byte mirror for the data-memory view of the PC
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pc_low_byte <= pmt_pkg::PC_RESET[pmt_pkg::BYTE_W-1:0];
    end else if (fetch) begin
      pc_low_byte <= pc_load ? pc_load_value[pmt_pkg::BYTE_W-1:0] :
                     pc_reg[pmt_pkg::BYTE_W-1:0] + 8'h01;
    end
  end

  // Fetched word is registered; valid only in cycles that really fetched
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_word_reg <= pmt_pkg::WORD_RESET;
      instr_addr_reg <= pmt_pkg::PC_RESET;
      instr_valid_reg <= 1'b0;
    end else begin
      instr_valid_reg <= fetch;
      if (fetch) begin
        instr_word_reg <= rd_word;
        instr_addr_reg <= pc_reg;
      end
    end
  end

  // ********************************************
  // Table pointer
  // ********************************************
  // Pointer is separate from the PC and only software moves it
  // Writes are held off while a read is in flight so the address is stable
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tbl_ptr_low_reg <= pmt_pkg::PTR_RESET;
      tbl_ptr_high_reg <= pmt_pkg::PTR_RESET;
    end else if (state_reg == pmt_pkg::PMT_ST_IDLE && !tab_rd_req) begin
      if (ptr_low_wr) begin
        tbl_ptr_low_reg <= ptr_wdata;
      end
      if (ptr_high_wr) begin
        tbl_ptr_high_reg <= ptr_wdata;
      end
    end
  end

  // Address captured on acceptance, last-page form forces the top page
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tab_addr_reg <= pmt_pkg::PC_RESET;
      dest_hold_reg <= pmt_pkg::PTR_RESET;
    end else if (tab_accept) begin
      tab_addr_reg <= table_address(tab_rd_lastpage, tbl_ptr_high_reg,
                                    tbl_ptr_low_reg);
      dest_hold_reg <= tab_rd_dest;
    end
  end

  // ********************************************
  // Table read results
  // ********************************************
  // Low byte goes out with a one-cycle write strobe to data memory
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tab_wr_en_reg <= 1'b0;
      tab_dest_reg <= pmt_pkg::PTR_RESET;
      tab_low_data_reg <= pmt_pkg::PTR_RESET;
    end else begin
      tab_wr_en_reg <= (state_reg == pmt_pkg::PMT_ST_TABLE);
      if (state_reg == pmt_pkg::PMT_ST_TABLE) begin
        tab_dest_reg <= dest_hold_reg;
        tab_low_data_reg <= rd_word[pmt_pkg::BYTE_W-1:0];
      end
    end
  end

  // No write path exists: an interrupting read will clobber it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      table_high_latch_reg <= pmt_pkg::PTR_RESET;
    end else if (state_reg == pmt_pkg::PMT_ST_TABLE) begin
      table_high_latch_reg <= rd_word[pmt_pkg::WORD_W-1:pmt_pkg::BYTE_W];
    end
  end

  assign table_high_latch = table_high_latch_reg;

  // ********************************************
  // Assertions
  // ********************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic first_seen_reg;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      first_seen_reg <= 1'b0;
    end else if (instr_valid_reg) begin
      first_seen_reg <= 1'b1;
    end
  end

  reset_vector_a: assert property (instr_valid_reg && !first_seen_reg |->
    instr_addr_reg == pmt_pkg::PC_RESET)
    else $error("first fetch not from reset vector");

  pc_increment_a: assert property (fetch && !pc_load |=>
    pc_reg == 12'($past(pc_reg) + 12'h001))
    else $error("pc did not advance by one");

  table_two_cycle_a: assert property (tab_accept |=> busy_reg && !instr_valid_reg
    ##1 tab_wr_en_reg && !busy_reg)
    else $error("table read not two cycles");

  table_addr_join_a: assert property (tab_accept && !tab_rd_lastpage |=>
    tab_addr_reg == {$past(tbl_ptr_high_reg[3:0]), $past(tbl_ptr_low_reg)})
    else $error("table address not pointer concatenation");

  last_page_a: assert property (tab_accept && tab_rd_lastpage |=>
    tab_addr_reg[11:8] == pmt_pkg::LAST_PAGE &&
    tab_addr_reg[7:0] == $past(tbl_ptr_low_reg))
    else $error("last page form used wrong page");

  dest_follow_a: assert property (tab_accept |-> ##2
    tab_dest_reg == $past(tab_rd_dest, 2))
    else $error("low byte sent to wrong destination");

  latch_only_read_a: assert property ($changed(table_high_latch_reg) |->
    tab_wr_en_reg)
    else $error("high latch changed without table read");

  latch_hold_a: assert property (!tab_wr_en_reg |-> $stable(table_high_latch_reg))
    else $error("high latch moved outside a table read");

  pointer_hold_a: assert property (busy_reg |-> $stable(tbl_ptr_low_reg) &&
    $stable(tbl_ptr_high_reg))
    else $error("table pointer moved during read");

  prog_drive_a: assert property (!prog_serial_data_oe_n |-> prog_mode ||
    $past(prog_mode))
    else $error("data pin driven outside programming");

  table_read_c: cover property (tab_accept && !tab_rd_lastpage ##2 tab_wr_en_reg);
  lastpage_read_c: cover property (tab_accept && tab_rd_lastpage ##2 tab_wr_en_reg);
  prog_write_c: cover property (prog_wr_en);
  // Next read is taken in the cycle that shows the previous write strobe
  back_to_back_c: cover property (tab_wr_en_reg ##1 busy_reg);

endmodule

`default_nettype wire

// ==== pmt_prog_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Programmer on the far side of the serial port
// ****************************************
module pmt_prog_model (
  input wire logic mclk,
  input wire logic dev_data_out,
  input wire logic dev_data_oe_n,
  output logic serial_clock,
  output wire logic data_line
);
  logic drive_en;
  logic drive_val;

  // Line has a pull-up, so a released line reads high and never keeps an old bit
  assign data_line = !dev_data_oe_n ? dev_data_out : (drive_en ? drive_val : 1'h1);

  // Clock parked low and line released outside frames
  initial begin
    serial_clock = 1'h0;
    drive_en = 1'h0;
    drive_val = 1'h0;
  end

  // One frame, address then data, MSB first; clock low and high one cycle each
  task automatic send_word(input logic [pmt_pkg::ADDR_W-1:0] addr,
                           input logic [pmt_pkg::WORD_W-1:0] data);
    logic [pmt_pkg::FRAME_BITS-1:0] frame;
    frame = {addr, data};
    for (int i = pmt_pkg::FRAME_BITS - 1; i >= 0; i--) begin
      @(posedge mclk);
      serial_clock <= 1'h0;
      drive_en <= 1'h1;
      drive_val <= frame[i];
      @(posedge mclk);
      serial_clock <= 1'h1;
    end
    // Let go of the line so the device alone may answer
    @(posedge mclk);
    serial_clock <= 1'h0;
    drive_en <= 1'h0;
  endtask
endmodule

`default_nettype wire

// ==== tb_program_memory_table_read.sv ====
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Testbench top
// ****************************************
module tb_program_memory_table_read;
  logic mclk, rst_n, cpu_step, pc_load, ptr_low_wr, ptr_high_wr, tab_rd_req;
  logic tab_rd_lastpage, prog_mode, serial_clock, data_line;
  logic prog_serial_data_out, prog_serial_data_oe_n, instr_valid_reg, busy_reg, tab_wr_en_reg;
  logic [pmt_pkg::ADDR_W-1:0] pc_load_value, pc_reg, instr_addr_reg, tab_addr_reg, exp_pc;
  logic [pmt_pkg::BYTE_W-1:0] ptr_wdata, tab_rd_dest, pc_low_byte, tbl_ptr_low_reg;
  logic [pmt_pkg::BYTE_W-1:0] tbl_ptr_high_reg, tab_dest_reg, tab_low_data_reg;
  logic [pmt_pkg::BYTE_W-1:0] table_high_latch, exp_latch;
  logic [pmt_pkg::WORD_W-1:0] instr_word_reg, exp_ptr;
  logic [pmt_pkg::WORD_W-1:0] mem [int];
  logic [pmt_pkg::ADDR_W-1:0] addr_list [$];
  int error_cnt = 0;
  int cmp_count = 0;

  pmt_top pmt_top_inst (.mclk(mclk), .rst_n(rst_n), .cpu_step(cpu_step), .pc_load(pc_load),
    .pc_load_value(pc_load_value), .ptr_low_wr(ptr_low_wr), .ptr_high_wr(ptr_high_wr),
    .ptr_wdata(ptr_wdata), .tab_rd_req(tab_rd_req), .tab_rd_lastpage(tab_rd_lastpage),
    .tab_rd_dest(tab_rd_dest), .prog_mode(prog_mode), .prog_serial_clock(serial_clock),
    .prog_serial_data_in(data_line), .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe_n(prog_serial_data_oe_n), .pc_reg(pc_reg), .pc_low_byte(pc_low_byte),
    .instr_word_reg(instr_word_reg), .instr_addr_reg(instr_addr_reg),
    .instr_valid_reg(instr_valid_reg), .busy_reg(busy_reg), .tbl_ptr_low_reg(tbl_ptr_low_reg),
    .tbl_ptr_high_reg(tbl_ptr_high_reg), .tab_addr_reg(tab_addr_reg),
    .tab_wr_en_reg(tab_wr_en_reg), .tab_dest_reg(tab_dest_reg),
    .tab_low_data_reg(tab_low_data_reg), .table_high_latch(table_high_latch));

  pmt_prog_model pmt_prog_model_inst (.mclk(mclk), .dev_data_out(prog_serial_data_out),
    .dev_data_oe_n(prog_serial_data_oe_n), .serial_clock(serial_clock), .data_line(data_line));

  // Free-running system clock
  initial begin
    mclk = 1'h0;
    forever #(pmt_pkg::MCLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  // Single compare; values are zero-extended and compared with !== so an unknown bit still fails
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Program one word; core asks for fetches throughout, which must be refused
  task automatic prog_word(input logic [11:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge mclk);
    prog_mode <= 1'h1;
    cpu_step <= 1'h1;
    pmt_prog_model_inst.send_word(addr, data);
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (prog_serial_data_oe_n !== 1'h0 && n < 8);
    chk("ack_oe_n", 16'h0000, prog_serial_data_oe_n);
    chk("ack_line", 16'h0000, data_line);
    @(posedge mclk);
    prog_mode <= 1'h0;
    cpu_step <= 1'h0;
    repeat (2) @(posedge mclk);
    #1;
    chk("oe_n_release", 16'h0001, prog_serial_data_oe_n);
    mem[addr] = data;
    addr_list.push_back(addr);
  endtask

  // Back-to-back fetches with random jumps, idle cycles and pointer writes
  task automatic run_fetch(input int n);
    logic step, ld, vstep;
    logic [11:0] tgt, vaddr;
    vstep = 1'h0;
    vaddr = 12'h000;
    for (int i = 0; i <= n; i++) begin
      @(posedge mclk);
      step = (i < n) && (i == 0 || $urandom_range(3) != 0);
      tgt = addr_list[$urandom_range(addr_list.size() - 1)];
      ld = step && (!mem.exists(exp_pc + 12'h001) || $urandom_range(3) == 0);
      cpu_step <= step;
      pc_load <= ld;
      pc_load_value <= ld ? tgt : 12'($urandom);
      ptr_low_wr <= (i < n) && 1'($urandom);
      ptr_high_wr <= (i < n) && 1'($urandom);
      ptr_wdata <= 8'($urandom);
      #1;
      chk("instr_valid", vstep, instr_valid_reg);
      if (vstep) chk("instr_addr", vaddr, instr_addr_reg);
      if (vstep) chk("instr_word", mem[vaddr], instr_word_reg);
      chk("pc", exp_pc, pc_reg);
      chk("pc_low", exp_pc[7:0], pc_low_byte);
      vstep = step;
      vaddr = exp_pc;
      if (step) exp_pc = ld ? tgt : exp_pc + 12'h001;
    end
    chk("latch_hold", exp_latch, table_high_latch);
  endtask

  // Set both pointers, then one table read with its two-cycle answer
  task automatic tab_read(input logic [11:0] addr, input logic lp, input logic [7:0] dest);
    logic [7:0] hi;
    hi = lp ? 8'($urandom) : {4'($urandom), addr[11:8]};
    @(posedge mclk);
    ptr_low_wr <= 1'h1;
    ptr_wdata <= addr[7:0];
    @(posedge mclk);
    ptr_low_wr <= 1'h0;
    ptr_high_wr <= 1'h1;
    ptr_wdata <= hi;
    @(posedge mclk);
    ptr_high_wr <= 1'h0;
    tab_rd_req <= 1'h1;
    tab_rd_lastpage <= lp;
    tab_rd_dest <= dest;
    @(posedge mclk);
    tab_rd_req <= 1'h0;
    #1;
    chk("busy", 16'h0001, busy_reg);
    chk("tab_addr", addr, tab_addr_reg);
    @(posedge mclk);
    #1;
    chk("wr_en", 16'h0001, tab_wr_en_reg);
    chk("dest", dest, tab_dest_reg);
    chk("low_data", mem[addr][7:0], tab_low_data_reg);
    chk("latch", mem[addr][15:8], table_high_latch);
    chk("ptr_low", addr[7:0], tbl_ptr_low_reg);
    chk("ptr_high", hi, tbl_ptr_high_reg);
    // The back-to-back reads reuse these pointers, so the latch keeps this value
    exp_latch = mem[addr][15:8];
    exp_ptr = {hi, addr[7:0]};
    @(posedge mclk);
    #1;
    chk("wr_en_pulse", 16'h0000, tab_wr_en_reg);
  endtask

  // Main sequence
  initial begin
    logic [11:0] a;
    void'($urandom(77));
    {rst_n, cpu_step, pc_load, ptr_low_wr, ptr_high_wr, tab_rd_req} = 6'h00;
    {tab_rd_lastpage, prog_mode} = 2'h0;
    pc_load_value = 12'h000;
    ptr_wdata = 8'h00;
    tab_rd_dest = 8'h00;
    exp_pc = pmt_pkg::PC_RESET;
    exp_latch = 8'h00;
    repeat (6) @(posedge mclk);
    rst_n <= 1'h1;
    @(posedge mclk);
    #1;
    chk("pc_reset", pmt_pkg::PC_RESET, pc_reg);
    chk("oe_n_reset", 16'h0001, prog_serial_data_oe_n);
    chk("latch_reset", 16'h0000, table_high_latch);
    $display("test reset done");
    for (int i = 0; i < 8; i++) prog_word(12'(i), 16'($urandom));
    for (int i = 0; i < 8; i++) prog_word(12'hF00 + 12'(i), 16'($urandom));
    for (int i = 0; i < 8; i++) prog_word(12'($urandom), 16'($urandom));
    chk("pc_frozen", pmt_pkg::PC_RESET, pc_reg);
    $display("test program done");
    run_fetch(60);
    $display("test fetch done");
    tab_read(12'hF06, 1'h1, 8'h20);
    tab_read(12'hF05, 1'h0, 8'h21);
    for (int i = 0; i < 24; i++) begin
      a = addr_list[$urandom_range(addr_list.size() - 1)];
      tab_read(a, (a[11:8] == pmt_pkg::LAST_PAGE) && 1'($urandom), 8'($urandom));
    end
    $display("test table read done");
    // Request held over three edges: taken at the first and third only;
    // pointer writes offered alongside must all be dropped
    @(posedge mclk);
    tab_rd_req <= 1'h1;
    ptr_low_wr <= 1'h1;
    ptr_high_wr <= 1'h1;
    ptr_wdata <= 8'($urandom);
    for (int k = 0; k < 5; k++) begin
      @(posedge mclk);
      if (k == 2) tab_rd_req <= 1'h0;
      if (k == 3) {ptr_low_wr, ptr_high_wr} <= 2'h0;
      #1;
      chk("b2b_busy", (k == 0 || k == 2), busy_reg);
      chk("b2b_wr_en", (k == 1 || k == 3), tab_wr_en_reg);
    end
    chk("ptr_hold", exp_ptr, {tbl_ptr_high_reg, tbl_ptr_low_reg});
    $display("test back to back done");
    run_fetch(30);
    $display("test latch hold done");
    final_report();
  end

  // Watchdog sized well above the fewer than two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end
endmodule

`default_nettype wire
